//--- logic/bvdpc_defines.vh
`ifndef BVDPC_DEFINES_VH
`define BVDPC_DEFINES_VH

// configuration dword offsets
`define BVDPC_OFF_BRIDGE_CTRL 8'h3c
`define BVDPC_OFF_PM_CAP 8'h40
`define BVDPC_OFF_PM_STAT_CTRL 8'h44

// bridge control / interrupt signal fields
`define BVDPC_INTR_LINE_LSB 0
`define BVDPC_INTR_PIN_LSB 8
`define BVDPC_PERR_RESP_BIT 16
`define BVDPC_SERR_EN_BIT 17
`define BVDPC_ISA_EN_BIT 18
`define BVDPC_VGA_EN_BIT 19
`define BVDPC_VGA16_BIT 20
`define BVDPC_SEC_RESET_BIT 22
`define BVDPC_INTR_PIN_RST 8'h01
`define BVDPC_INTR_LINE_RST 8'h00
`define BVDPC_BRIDGE_RST 1'b0

// power management capability fields
`define BVDPC_CAP_ID_LSB 0
`define BVDPC_NEXT_PTR_LSB 8
`define BVDPC_VERSION_LSB 16
`define BVDPC_DSI_BIT 21
`define BVDPC_AUX_CUR_LSB 22
`define BVDPC_PME_SUP_LSB 27
`define BVDPC_CAP_ID_RST 8'h01
`define BVDPC_NEXT_PTR_RST 8'h48
`define BVDPC_VERSION_RST 3'h3
`define BVDPC_DSI_RST 1'b0
`define BVDPC_AUX_CUR_RST 3'h0
`define BVDPC_PME_SUP_RST 5'h19

// power management status/control fields
`define BVDPC_PWR_STATE_LSB 0
`define BVDPC_NO_SOFT_RST_BIT 3
`define BVDPC_PME_EN_BIT 8
`define BVDPC_PME_STAT_BIT 15
`define BVDPC_PWR_D0 2'h0
`define BVDPC_PWR_D3HOT 2'h3
`define BVDPC_NO_SOFT_RST_RST 1'b1
`define BVDPC_PME_RST 1'b0

// command register bits and legacy display windows
`define BVDPC_CMD_IO_BIT 0
`define BVDPC_CMD_MEM_BIT 1
`define BVDPC_VGA_MEM_LO 32'h000a0000
`define BVDPC_VGA_MEM_HI 32'h000bffff
`define BVDPC_VGA_IO_A_LO 10'h3b0
`define BVDPC_VGA_IO_A_HI 10'h3bb
`define BVDPC_VGA_IO_B_LO 10'h3c0
`define BVDPC_VGA_IO_B_HI 10'h3df

`endif

//--- logic/bvdpc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "bvdpc_defines.vh"

module bvdpc_top (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_ce,
  // configuration access
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [7:0] i_cfg_addr,
  input wire [31:0] i_cfg_wdata,
  input wire [3:0] i_cfg_be,
  output reg [31:0] o_cfg_rdata,
  output reg o_cfg_rvalid,
  // serial eeprom / two-wire preset loader
  input wire i_ld_wr,
  input wire [7:0] i_ld_addr,
  input wire [31:0] i_ld_wdata,
  // command register state and programmed windows, from config space
  input wire [1:0] i_cmd_access_en,
  input wire i_pri_mem_win_hit,
  input wire i_pri_io_win_hit,
  input wire i_sec_mem_win_hit,
  input wire i_sec_io_win_hit,
  input wire i_egress_port,
  // request decode, primary side
  input wire [31:0] i_pri_addr,
  input wire i_pri_is_io,
  output wire o_pri_fwd,
  // request decode, secondary side
  input wire [31:0] i_sec_addr,
  input wire i_sec_is_io,
  output wire o_sec_fwd,
  // control outputs
  output reg o_hot_reset,
  output reg o_store_fwd,
  output wire o_vga_en,
  output wire [1:0] o_pwr_state
);

  // writable bridge control state
  reg [7:0] intr_line_q;
  reg [7:0] intr_pin_q;
  reg perr_resp_q;
  reg serr_en_q;
  reg isa_en_q;
  reg vga_en_q;
  reg vga16_q;
  reg sec_reset_q;

  // capability fields, loader-presettable only
  reg [7:0] cap_id_q;
  reg [7:0] next_ptr_q;
  reg [2:0] version_q;
  reg dsi_q;
  reg [2:0] aux_cur_q;
  reg [4:0] pme_sup_q;

  // pm status/control
  reg [1:0] pwr_state_q;
  reg no_soft_rst_q;
  reg pme_en_q;
  reg pme_stat_q;

  wire wr_bc = i_cfg_wr && (i_cfg_addr == `BVDPC_OFF_BRIDGE_CTRL);
  wire wr_ps = i_cfg_wr && (i_cfg_addr == `BVDPC_OFF_PM_STAT_CTRL);
  wire ld_bc = i_ld_wr && (i_ld_addr == `BVDPC_OFF_BRIDGE_CTRL);
  wire ld_cap = i_ld_wr && (i_ld_addr == `BVDPC_OFF_PM_CAP);
  wire ld_ps = i_ld_wr && (i_ld_addr == `BVDPC_OFF_PM_STAT_CTRL);

  wire [1:0] new_state = i_cfg_wdata[`BVDPC_PWR_STATE_LSB +: 2];
  wire state_ok = (new_state == `BVDPC_PWR_D0) ||
                  (new_state == `BVDPC_PWR_D3HOT);

  // next values; a loader preset wins over a config write to the same dword
  reg [7:0] intr_line_d;
  reg [7:0] intr_pin_d;
  reg perr_resp_d;
  reg serr_en_d;
  reg isa_en_d;
  reg vga_en_d;
  reg vga16_d;
  reg sec_reset_d;
  reg [7:0] cap_id_d;
  reg [7:0] next_ptr_d;
  reg [2:0] version_d;
  reg dsi_d;
  reg [2:0] aux_cur_d;
  reg [4:0] pme_sup_d;
  reg [1:0] pwr_state_d;
  reg no_soft_rst_d;
  reg pme_en_d;
  reg pme_stat_d;
  wire [1:0] ld_state = i_ld_wdata[`BVDPC_PWR_STATE_LSB +: 2];
  wire ld_state_ok = (ld_state == `BVDPC_PWR_D0) ||
                     (ld_state == `BVDPC_PWR_D3HOT);

  // bridge control; config writes reach only the interrupt line in byte 0 and bits 16-20 and 22 of byte 2
  always @* begin
    intr_line_d = intr_line_q;
    intr_pin_d = intr_pin_q;
    perr_resp_d = perr_resp_q;
    serr_en_d = serr_en_q;
    isa_en_d = isa_en_q;
    vga_en_d = vga_en_q;
    vga16_d = vga16_q;
    sec_reset_d = sec_reset_q;
    if (ld_bc) begin
      intr_line_d = i_ld_wdata[`BVDPC_INTR_LINE_LSB +: 8];
      intr_pin_d = i_ld_wdata[`BVDPC_INTR_PIN_LSB +: 8];
      perr_resp_d = i_ld_wdata[`BVDPC_PERR_RESP_BIT];
      serr_en_d = i_ld_wdata[`BVDPC_SERR_EN_BIT];
      isa_en_d = i_ld_wdata[`BVDPC_ISA_EN_BIT];
      vga_en_d = i_ld_wdata[`BVDPC_VGA_EN_BIT];
      vga16_d = i_ld_wdata[`BVDPC_VGA16_BIT];
      sec_reset_d = i_ld_wdata[`BVDPC_SEC_RESET_BIT];
    end else if (wr_bc) begin
      if (i_cfg_be[0]) begin
        intr_line_d = i_cfg_wdata[`BVDPC_INTR_LINE_LSB +: 8];
      end
      if (i_cfg_be[2]) begin
        perr_resp_d = i_cfg_wdata[`BVDPC_PERR_RESP_BIT];
        serr_en_d = i_cfg_wdata[`BVDPC_SERR_EN_BIT];
        isa_en_d = i_cfg_wdata[`BVDPC_ISA_EN_BIT];
        vga_en_d = i_cfg_wdata[`BVDPC_VGA_EN_BIT];
        vga16_d = i_cfg_wdata[`BVDPC_VGA16_BIT];
        sec_reset_d = i_cfg_wdata[`BVDPC_SEC_RESET_BIT];
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      intr_line_q <= `BVDPC_INTR_LINE_RST;
      intr_pin_q <= `BVDPC_INTR_PIN_RST;
      perr_resp_q <= `BVDPC_BRIDGE_RST;
      serr_en_q <= `BVDPC_BRIDGE_RST;
      isa_en_q <= `BVDPC_BRIDGE_RST;
      vga_en_q <= `BVDPC_BRIDGE_RST;
      vga16_q <= `BVDPC_BRIDGE_RST;
      sec_reset_q <= `BVDPC_BRIDGE_RST;
    end else if (i_ce) begin
      intr_line_q <= intr_line_d;
      intr_pin_q <= intr_pin_d;
      perr_resp_q <= perr_resp_d;
      serr_en_q <= serr_en_d;
      isa_en_q <= isa_en_d;
      vga_en_q <= vga_en_d;
      vga16_q <= vga16_d;
      sec_reset_q <= sec_reset_d;
    end
  end

  // capability header is read-only to config; only the loader reaches it
  always @* begin
    cap_id_d = cap_id_q;
    next_ptr_d = next_ptr_q;
    version_d = version_q;
    dsi_d = dsi_q;
    aux_cur_d = aux_cur_q;
    pme_sup_d = pme_sup_q;
    if (ld_cap) begin
      cap_id_d = i_ld_wdata[`BVDPC_CAP_ID_LSB +: 8];
      next_ptr_d = i_ld_wdata[`BVDPC_NEXT_PTR_LSB +: 8];
      version_d = i_ld_wdata[`BVDPC_VERSION_LSB +: 3];
      dsi_d = i_ld_wdata[`BVDPC_DSI_BIT];
      aux_cur_d = i_ld_wdata[`BVDPC_AUX_CUR_LSB +: 3];
      pme_sup_d = i_ld_wdata[`BVDPC_PME_SUP_LSB +: 5];
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_id_q <= `BVDPC_CAP_ID_RST;
      next_ptr_q <= `BVDPC_NEXT_PTR_RST;
      version_q <= `BVDPC_VERSION_RST;
      dsi_q <= `BVDPC_DSI_RST;
      aux_cur_q <= `BVDPC_AUX_CUR_RST;
      pme_sup_q <= `BVDPC_PME_SUP_RST;
    end else if (i_ce) begin
      cap_id_q <= cap_id_d;
      next_ptr_q <= next_ptr_d;
      version_q <= version_d;
      dsi_q <= dsi_d;
      aux_cur_q <= aux_cur_d;
      pme_sup_q <= pme_sup_d;
    end
  end

  // power state: unsupported encodings are discarded, from either source
  always @* begin
    pwr_state_d = pwr_state_q;
    no_soft_rst_d = no_soft_rst_q;
    pme_en_d = pme_en_q;
    pme_stat_d = pme_stat_q;
    if (ld_ps) begin
      no_soft_rst_d = i_ld_wdata[`BVDPC_NO_SOFT_RST_BIT];
      if (ld_state_ok) begin
        pwr_state_d = ld_state;
      end
    end else if (wr_ps) begin
      if (i_cfg_be[0] && state_ok) begin
        pwr_state_d = new_state;
      end
      if (i_cfg_be[1]) begin
        pme_en_d = i_cfg_wdata[`BVDPC_PME_EN_BIT];
        // write-one-to-clear; nothing in this block sets the status
        if (i_cfg_wdata[`BVDPC_PME_STAT_BIT]) begin
          pme_stat_d = 1'b0;
        end
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_state_q <= `BVDPC_PWR_D0;
      no_soft_rst_q <= `BVDPC_NO_SOFT_RST_RST;
      pme_en_q <= `BVDPC_PME_RST;
      pme_stat_q <= `BVDPC_PME_RST;
    end else if (i_ce) begin
      pwr_state_q <= pwr_state_d;
      no_soft_rst_q <= no_soft_rst_d;
      pme_en_q <= pme_en_d;
      pme_stat_q <= pme_stat_d;
    end
  end

  // read words; reserved and unimplemented bits read zero
  reg [31:0] bc_word;
  reg [31:0] cap_word;
  reg [31:0] ps_word;
  reg [31:0] rd_d;
  always @* begin
    bc_word = 32'h00000000;
    bc_word[`BVDPC_INTR_LINE_LSB +: 8] = intr_line_q;
    bc_word[`BVDPC_INTR_PIN_LSB +: 8] = intr_pin_q;
    bc_word[`BVDPC_PERR_RESP_BIT] = perr_resp_q;
    bc_word[`BVDPC_SERR_EN_BIT] = serr_en_q;
    bc_word[`BVDPC_ISA_EN_BIT] = isa_en_q;
    bc_word[`BVDPC_VGA_EN_BIT] = vga_en_q;
    bc_word[`BVDPC_VGA16_BIT] = vga16_q;
    bc_word[`BVDPC_SEC_RESET_BIT] = sec_reset_q;
  end

  always @* begin
    cap_word = 32'h00000000;
    cap_word[`BVDPC_CAP_ID_LSB +: 8] = cap_id_q;
    cap_word[`BVDPC_NEXT_PTR_LSB +: 8] = next_ptr_q;
    cap_word[`BVDPC_VERSION_LSB +: 3] = version_q;
    cap_word[`BVDPC_DSI_BIT] = dsi_q;
    cap_word[`BVDPC_AUX_CUR_LSB +: 3] = aux_cur_q;
    cap_word[`BVDPC_PME_SUP_LSB +: 5] = pme_sup_q;
  end

  always @* begin
    ps_word = 32'h00000000;
    ps_word[`BVDPC_PWR_STATE_LSB +: 2] = pwr_state_q;
    ps_word[`BVDPC_NO_SOFT_RST_BIT] = no_soft_rst_q;
    ps_word[`BVDPC_PME_EN_BIT] = pme_en_q;
    ps_word[`BVDPC_PME_STAT_BIT] = pme_stat_q;
  end

  always @* begin
    case (i_cfg_addr)
      `BVDPC_OFF_BRIDGE_CTRL: rd_d = bc_word;
      `BVDPC_OFF_PM_CAP: rd_d = cap_word;
      `BVDPC_OFF_PM_STAT_CTRL: rd_d = ps_word;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h00000000;
      o_cfg_rvalid <= 1'b0;
      o_hot_reset <= 1'b0;
      o_store_fwd <= 1'b0;
    end else if (i_ce) begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd) begin
        o_cfg_rdata <= rd_d;
      end
      o_hot_reset <= sec_reset_q;
      o_store_fwd <= vga_en_q && i_egress_port;
    end
  end

  wire pri_hit;
  wire sec_hit;
  bvdpc_vga_match u_pri_match (
    .i_addr(i_pri_addr),
    .i_is_io(i_pri_is_io),
    .i_vga16(vga16_q),
    .o_hit(pri_hit)
  );
  bvdpc_vga_match u_sec_match (
    .i_addr(i_sec_addr),
    .i_is_io(i_sec_is_io),
    .i_vga16(vga16_q),
    .o_hit(sec_hit)
  );

  wire pri_en = i_pri_is_io ? i_cmd_access_en[`BVDPC_CMD_IO_BIT] :
                              i_cmd_access_en[`BVDPC_CMD_MEM_BIT];
  wire sec_en = i_sec_is_io ? i_cmd_access_en[`BVDPC_CMD_IO_BIT] :
                              i_cmd_access_en[`BVDPC_CMD_MEM_BIT];
  wire pri_win = i_pri_is_io ? i_pri_io_win_hit : i_pri_mem_win_hit;
  wire sec_win = i_sec_is_io ? i_sec_io_win_hit : i_sec_mem_win_hit;

  // vga hit bypasses windows and isa enable, but still needs the command access enable bit
  assign o_pri_fwd = pri_en &&
                     ((vga_en_q && pri_hit) || pri_win);
  // upstream traffic goes when outside the downstream windows and not a vga hit while vga enable is set
  assign o_sec_fwd = sec_en && !sec_win &&
                     !(vga_en_q && sec_hit);
  assign o_vga_en = vga_en_q;
  assign o_pwr_state = pwr_state_q;

endmodule

`default_nettype wire

//--- logic/bvdpc_vga_match.v
`timescale 1ns/1ps
`default_nettype none
`include "bvdpc_defines.vh"

// legacy display address match for one direction of traffic
module bvdpc_vga_match (
  input wire [31:0] i_addr,
  input wire i_is_io,
  input wire i_vga16,
  output wire o_hit
);
  wire [9:0] lo10 = i_addr[9:0];
  wire io_range = ((lo10 >= `BVDPC_VGA_IO_A_LO) &&
                   (lo10 <= `BVDPC_VGA_IO_A_HI)) ||
                  ((lo10 >= `BVDPC_VGA_IO_B_LO) &&
                   (lo10 <= `BVDPC_VGA_IO_B_HI));
  // 10-bit compare ignores aliases in bits 15:10 unless i_vga16 is set, which requires bits 15:10 to be zero
  wire io_alias_ok = i_vga16 ? (i_addr[15:10] == 6'h00) : 1'b1;
  wire io_hit = (i_addr[31:16] == 16'h0000) && io_range && io_alias_ok;
  wire mem_hit = (i_addr >= `BVDPC_VGA_MEM_LO) &&
                 (i_addr <= `BVDPC_VGA_MEM_HI);
  assign o_hit = i_is_io ? io_hit : mem_hit;
endmodule

`default_nettype wire

//--- tb/bvdpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bvdpc_checker (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  input wire logic i_ld_wr,
  input wire logic [1:0] i_cmd_access_en,
  input wire logic i_pri_mem_win_hit,
  input wire logic i_pri_io_win_hit,
  input wire logic i_egress_port,
  input wire logic [31:0] i_pri_addr,
  input wire logic i_pri_is_io,
  input wire logic o_pri_fwd,
  input wire logic [31:0] i_sec_addr,
  input wire logic i_sec_is_io,
  input wire logic o_sec_fwd,
  input wire logic o_hot_reset,
  input wire logic o_store_fwd,
  input wire logic o_vga_en
);
  wire [9:0] pa = i_pri_addr[9:0];
  wire pio = i_pri_addr[31:10] == 22'h0 &&
    (pa >= 10'h3b0 && pa <= 10'h3bb || pa >= 10'h3c0 && pa <= 10'h3df);
  wire pmem = i_pri_addr >= 32'h000a0000 && i_pri_addr <= 32'h000bffff;
  wire smem = i_sec_addr >= 32'h000a0000 && i_sec_addr <= 32'h000bffff;
  wire cfg_go = i_cfg_wr && i_ce && !i_ld_wr && i_cfg_addr == 8'h3c;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_mem_fwd;
    o_vga_en && i_cmd_access_en[1] && !i_pri_is_io && pmem |-> o_pri_fwd;
  endproperty
  a_mem_fwd: assert property (p_mem_fwd) else $error("vga mem lost");
  property p_io_fwd;
    o_vga_en && i_cmd_access_en[0] && i_pri_is_io && pio |-> o_pri_fwd;
  endproperty
  a_io_fwd: assert property (p_io_fwd) else $error("vga io lost");
  property p_sec_block;
    o_vga_en && !i_sec_is_io && smem |-> !o_sec_fwd;
  endproperty
  a_sec_block: assert property (p_sec_block) else $error("sec leak");
  property p_access;
    !(i_pri_is_io ? i_cmd_access_en[0] : i_cmd_access_en[1]) |-> !o_pri_fwd;
  endproperty
  a_access: assert property (p_access) else $error("fwd disabled");
  property p_win_only;
    !o_vga_en && !i_pri_mem_win_hit && !i_pri_io_win_hit |-> !o_pri_fwd;
  endproperty
  a_win_only: assert property (p_win_only) else $error("fwd no win");
  property p_store;
    $past(i_ce) |-> o_store_fwd == $past(o_vga_en && i_egress_port);
  endproperty
  a_store: assert property (p_store) else $error("store fwd");
  property p_hot;
    cfg_go && i_cfg_be[2] && i_cfg_wdata[22] ##1 i_ce |=> o_hot_reset;
  endproperty
  a_hot: assert property (p_hot) else $error("hot reset missing");
  property p_rd_rsvd;
    i_cfg_rd && i_ce && i_cfg_addr == 8'h3c |=>
      o_cfg_rvalid && o_cfg_rdata[31:23] == 9'h0 && !o_cfg_rdata[21];
  endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("rsvd bits");
  c_mem: cover property (o_vga_en && pmem && o_pri_fwd);
  c_io: cover property (o_vga_en && pio && i_pri_is_io && o_pri_fwd);
  c_hot: cover property (o_hot_reset && o_store_fwd);
endmodule
bind bvdpc_top bvdpc_checker u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_ce(i_ce), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
  .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata), .i_cfg_be(i_cfg_be),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .i_ld_wr(i_ld_wr),
  .i_cmd_access_en(i_cmd_access_en), .i_pri_mem_win_hit(i_pri_mem_win_hit),
  .i_pri_io_win_hit(i_pri_io_win_hit), .i_egress_port(i_egress_port),
  .i_pri_addr(i_pri_addr), .i_pri_is_io(i_pri_is_io), .o_pri_fwd(o_pri_fwd),
  .i_sec_addr(i_sec_addr), .i_sec_is_io(i_sec_is_io), .o_sec_fwd(o_sec_fwd),
  .o_hot_reset(o_hot_reset), .o_store_fwd(o_store_fwd), .o_vga_en(o_vga_en));
`default_nettype wire

//--- tb/test_bridge_vga_decode_pm_cap.sv
`timescale 1ns/1ps
`default_nettype none
module test_bridge_vga_decode_pm_cap;
  logic clk = 0, rst = 1, ce = 1, cwr = 0, crd = 0, lwr = 0;
  logic [7:0] ca = 0, la = 0;
  logic [31:0] cd = 0, ld = 0, pa = 0, sa = 0, r, r2;
  logic [3:0] be = 0;
  logic [1:0] cen = 0;
  logic pm = 0, pi = 0, sm = 0, si = 0, eg = 0, pio = 0, sio = 0;
  wire [31:0] rdata;
  wire rv, pf, sf, hr, sfw, ve;
  wire [1:0] ps;
  integer error_cnt = 0, tests_run = 0, seed = 73, i, j;
  logic [31:0] m3c = 32'h00000100, m40 = 32'hc8034801, m44 = 32'h00000008;
  bvdpc_top dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_cfg_wr(cwr),
    .i_cfg_rd(crd), .i_cfg_addr(ca), .i_cfg_wdata(cd), .i_cfg_be(be),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rv), .i_ld_wr(lwr), .i_ld_addr(la),
    .i_ld_wdata(ld), .i_cmd_access_en(cen), .i_pri_mem_win_hit(pm),
    .i_pri_io_win_hit(pi), .i_sec_mem_win_hit(sm), .i_sec_io_win_hit(si),
    .i_egress_port(eg), .i_pri_addr(pa), .i_pri_is_io(pio), .o_pri_fwd(pf),
    .i_sec_addr(sa), .i_sec_is_io(sio), .o_sec_fwd(sf), .o_hot_reset(hr),
    .o_store_fwd(sfw), .o_vga_en(ve), .o_pwr_state(ps));
  initial forever #50 clk = ~clk;
  task tk;
    @(posedge clk);
    #10;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] b);
    logic [31:0] mk;
    mk = {8'h0, b[2] ? 8'h5f : 8'h0, 8'h0, b[0] ? 8'hff : 8'h0};
    ca = a;
    cd = d;
    be = b;
    cwr = 1;
    tk;
    cwr = 0;
    if (ce && a == 8'h3c)
      m3c = m3c & ~mk | d & mk;
    if (ce && a == 8'h44 && b[0] && (d[1:0] == 2'h0 || d[1:0] == 2'h3))
      m44[1:0] = d[1:0];
    if (ce && a == 8'h44 && b[1])
      m44[8] = d[8];
  endtask
  task rd(input [7:0] a, input [31:0] e);
    ca = a;
    crd = 1;
    tk;
    crd = 0;
    chk("rvalid", 1, rv);
    chk("rdata", e, rdata);
    tk;
  endtask
  function logic vh(input [31:0] a, input logic io, input logic w16);
    if (!io)
      return a >= 32'h000a0000 && a <= 32'h000bffff;
    return a[31:16] == 16'h0 && (!w16 || a[15:10] == 6'h0) &&
      (a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb ||
       a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df);
  endfunction
  task complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clk);
    #10;
    rst = 0;
    rd(8'h3c, m3c);
    rd(8'h40, m40);
    rd(8'h44, m44);
    for (j = 0; j < 4; j++) begin
      eg = j[1];
      wr(8'h3c, {11'h0, j[1:0], 19'h0}, 4'h4);
      chk("vga_en", j[0], ve);
      tk;
      chk("store_fwd", j[0] & j[1], sfw);
      for (i = 0; i < 200; i++) begin
        r = $random(seed);
        r2 = $random(seed);
        {si, sm, pi, pm, cen, sio, pio} = r[7:0] & {8{r[8]}};
        pa = pio ? {15'h0, r2[16] & r2[17], r2[15:10] & {6{r2[18]}},
          10'h3a0 + r2[5:0]} : 32'h98000 + r2[17:0];
        sa = sio ? {22'h0, 10'h3a0 + r2[25:20]} : 32'h98000 + r[31:14];
        #1;
        chk("pri_fwd", (pio ? cen[0] : cen[1]) && (m3c[19] &&
          vh(pa, pio, m3c[20]) || (pio ? pi : pm)), pf);
        chk("sec_fwd", (sio ? cen[0] : cen[1]) && !(sio ? si : sm) &&
          !(m3c[19] && vh(sa, sio, m3c[20])), sf);
        tk;
      end
    end
    {si, sm, pi, pm} = 4'h0;
    cen = 2'h3;
    wr(8'h3c, 32'h000c0000, 4'h4);
    {pio, sio} = 2'h3;
    pa = 32'h00000bb0;
    sa = 32'h000007c4;
    #1;
    chk("pri_fwd_isa", 1, pf);
    chk("sec_blk_alias", 0, sf);
    tk;
    wr(8'h3c, 32'h00400000, 4'h4);
    tk;
    chk("hot_reset", 1, hr);
    wr(8'h3c, 32'h0, 4'h4);
    tk;
    chk("hot_reset", 0, hr);
    wr(8'h3c, 32'hffffffff, 4'hf);
    rd(8'h3c, m3c);
    wr(8'h40, 32'hffffffff, 4'hf);
    rd(8'h40, m40);
    la = 8'h40;
    ld = 32'h08e25001;
    lwr = 1;
    tk;
    lwr = 0;
    m40 = ld;
    rd(8'h40, m40);
    for (j = 0; j < 4; j++) begin
      wr(8'h44, j, 4'h1);
      rd(8'h44, m44);
      chk("pwr_state", m44[1:0], ps);
    end
    wr(8'h44, 32'hffffffff, 4'hf);
    rd(8'h44, m44);
    wr(8'h50, 32'hffffffff, 4'hf);
    rd(8'h50, 32'h0);
    ce = 0;
    wr(8'h3c, 32'h0, 4'hf);
    ce = 1;
    rd(8'h3c, m3c);
    complete_run;
  end
endmodule
`default_nettype wire
